// file: hw/asr_defines.vh
// Purpose: timing and width constants for the static memory host controller
// Assumes: 100 MHz mclk, slower speed grade timings used throughout
// Notes: all counts are in mclk cycles derived from ns figures, the recovery count from the ms figure
`ifndef ASR_DEFINES_VH
`define ASR_DEFINES_VH
`define ASR_CLK_NS 10
`define ASR_ADDR_W 18
`define ASR_DATA_W 8
// slower grade figures
`define ASR_T_ACC_NS 70
`define ASR_T_OE_ACC_NS 35
`define ASR_T_DIS_NS 25
`define ASR_T_WP_NS 55
`define ASR_T_DSU_NS 30
`define ASR_T_ASU_NS 65
`define ASR_T_CYC_NS 70
`define ASR_T_REC_PD_MS 5
// least times round up
`define ASR_ACC_CYC ((`ASR_T_ACC_NS + `ASR_CLK_NS - 1) / `ASR_CLK_NS)
`define ASR_DIS_CYC ((`ASR_T_DIS_NS + `ASR_CLK_NS - 1) / `ASR_CLK_NS)
`define ASR_WP_CYC ((`ASR_T_ASU_NS + `ASR_CLK_NS - 1) / `ASR_CLK_NS)
`define ASR_REC_PD_CYC (`ASR_T_REC_PD_MS * 1000000 / `ASR_CLK_NS)
`define ASR_CNT_W 8
`endif

// file: hw/asr_host.v
// Purpose: host controller driving an asynchronous 256k x 8 static memory
// Assumes: single mclk at 100 MHz; pin inputs synchronous to mclk
// Notes: one access at a time; req taken only while ready is high
// a read holds oe low for the full address access time, then waits out the bus release
// a write drops the strobe together with the selects, so the memory never drives during it
// pd_exit aborts any access in flight and restarts the recovery wait
// limitation: slower speed grade only; a fast grade part simply runs with margin
// trade-off: whole-cycle counts cost up to one cycle per phase against exact ns figures
// the strobe ends a normal write, selects and data one cycle later as hold; pd_exit releases all of them on one edge
`include "asr_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module asr_host #(
  parameter REC_PD_CYC = `ASR_REC_PD_CYC
) (
  // clock and reset
  input wire mclk,
  input wire rst,
  // user side
  input wire req,
  input wire req_write,
  input wire [`ASR_ADDR_W-1:0] req_addr,
  input wire [`ASR_DATA_W-1:0] req_wdata,
  input wire pd_exit,
  output reg ready,
  output reg rd_valid,
  output reg [`ASR_DATA_W-1:0] rd_data,
  // memory pins
  output reg [`ASR_ADDR_W-1:0] mem_addr,
  output reg select_low_active_n,
  output reg select_high_active,
  output reg mem_we_n,
  output reg mem_oe_n,
  input wire [`ASR_DATA_W-1:0] mem_dq_in,
  output reg [`ASR_DATA_W-1:0] mem_dq_out,
  output reg mem_dq_oe
);
  // ==========================================================
  // state codes, one bit per state
  localparam [5:0] ST_WAIT = 6'h01;
  localparam [5:0] ST_IDLE = 6'h02;
  localparam [5:0] ST_RD = 6'h04;
  localparam [5:0] ST_RD_END = 6'h08;
  localparam [5:0] ST_WR = 6'h10;
  localparam [5:0] ST_WR_END = 6'h20;
  // ==========================================================
  // timing counts, cut on purpose to the counter width
  localparam [31:0] ACC_FULL = `ASR_ACC_CYC;
  localparam [31:0] DIS_FULL = `ASR_DIS_CYC;
  localparam [31:0] WP_FULL = `ASR_WP_CYC;
  localparam [31:0] REC_FULL = REC_PD_CYC;
  localparam [`ASR_CNT_W-1:0] ACC_CYC = ACC_FULL[`ASR_CNT_W-1:0];
  localparam [`ASR_CNT_W-1:0] DIS_CYC = DIS_FULL[`ASR_CNT_W-1:0];
  localparam [`ASR_CNT_W-1:0] WP_CYC = WP_FULL[`ASR_CNT_W-1:0];
  localparam [`ASR_CNT_W-1:0] ONE = 8'h01;
  // 23 bits cover the 5 ms wait at 100 MHz with room to spare
  localparam [22:0] REC_LD = REC_FULL[22:0];

  // ==========================================================
  // state registers
  reg [5:0] state_q;
  reg [`ASR_CNT_W-1:0] cnt_q;
  reg [22:0] pd_cnt_q;

  // ==========================================================
  // count decode, shared by the read, bus release and write states; the recovery wait tests pd_cnt_q itself
  function cnt_zero;
    input [`ASR_CNT_W-1:0] c;
    begin
      cnt_zero = (c == 8'h00);
    end
  endfunction

  // ==========================================================
  // access sequencer
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      // pins idle: memory deselected, bus released
      state_q <= ST_WAIT;
      cnt_q <= 8'h00;
      pd_cnt_q <= 23'h000000;
      ready <= 1'b0;
      rd_valid <= 1'b0;
      rd_data <= 8'h00;
      mem_addr <= 18'h00000;
      select_low_active_n <= 1'b1;
      select_high_active <= 1'b0;
      mem_we_n <= 1'b1;
      mem_oe_n <= 1'b1;
      mem_dq_out <= 8'h00;
      mem_dq_oe <= 1'b0;
    end else begin
      // rd_valid is a one-cycle pulse
      rd_valid <= 1'b0;
      if (pd_exit) begin
        // recovery wait
        // a write cut here ends with strobe, selects and data released on the same edge
        state_q <= ST_WAIT;
        pd_cnt_q <= REC_LD;
        ready <= 1'b0;
        select_low_active_n <= 1'b1;
        select_high_active <= 1'b0;
        mem_we_n <= 1'b1;
        mem_oe_n <= 1'b1;
        mem_dq_oe <= 1'b0;
      end else begin
        case (state_q)
          ST_WAIT: begin
            // recovery count runs out before the first access
            if (pd_cnt_q == 23'h000000) begin
              state_q <= ST_IDLE;
              ready <= 1'b1;
            end else begin
              pd_cnt_q <= pd_cnt_q - 23'h000001;
            end
          end
          ST_IDLE: begin
            if (req) begin
              ready <= 1'b0;
              mem_addr <= req_addr;
              select_low_active_n <= 1'b0;
              select_high_active <= 1'b1;
              if (req_write) begin
                mem_we_n <= 1'b0;
                mem_oe_n <= 1'b1;
                mem_dq_out <= req_wdata;
                mem_dq_oe <= 1'b1;
                cnt_q <= WP_CYC - ONE;
                state_q <= ST_WR;
              end else begin
                mem_dq_oe <= 1'b0;
                // output enable time lies inside the address access time
                mem_oe_n <= 1'b0;
                cnt_q <= ACC_CYC - ONE;
                state_q <= ST_RD;
              end
            end
          end
          ST_RD: begin
            // no margin beyond the access time: sampled exactly when it has run out
            if (cnt_zero(cnt_q)) begin
              rd_data <= mem_dq_in;
              rd_valid <= 1'b1;
              mem_oe_n <= 1'b1;
              select_low_active_n <= 1'b1;
              select_high_active <= 1'b0;
              cnt_q <= DIS_CYC - ONE;
              state_q <= ST_RD_END;
            end else begin
              cnt_q <= cnt_q - ONE;
            end
          end
          ST_RD_END: begin
            if (cnt_zero(cnt_q)) begin
              state_q <= ST_IDLE;
              ready <= 1'b1;
            end else begin
              cnt_q <= cnt_q - ONE;
            end
          end
          ST_WR: begin
            // address and selects stand unchanged while the strobe is low
            if (cnt_zero(cnt_q)) begin
              mem_we_n <= 1'b1;
              state_q <= ST_WR_END;
            end else begin
              cnt_q <= cnt_q - ONE;
            end
          end
          ST_WR_END: begin
            // data and address held one cycle past strobe rise
            select_low_active_n <= 1'b1;
            select_high_active <= 1'b0;
            mem_dq_oe <= 1'b0;
            state_q <= ST_IDLE;
            ready <= 1'b1;
          end
          default: begin
            // an illegal one-hot code parks the pins, then waits out a bus release
            select_low_active_n <= 1'b1;
            select_high_active <= 1'b0;
            mem_we_n <= 1'b1;
            mem_oe_n <= 1'b1;
            mem_dq_oe <= 1'b0;
            ready <= 1'b0;
            cnt_q <= DIS_CYC - ONE;
            state_q <= ST_RD_END;
          end
        endcase
      end
    end
  end
endmodule // asr_host
`default_nettype wire

// file: verif/asr_host_assertions.sv
// Purpose: pin checks. Assumes: one clock. Notes: bound below
`timescale 1ns/1ps
`default_nettype none
module asr_host_assertions (
  input wire logic mclk, rst, pd_exit, ready, select_low_active_n, select_high_active,
  input wire logic mem_we_n, mem_oe_n, mem_dq_oe,
  input wire logic [17:0] mem_addr,
  input wire logic [7:0] mem_dq_out
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence wr_on; !mem_we_n && !$past(mem_we_n); endsequence
  sequence wr_pulse; !mem_we_n [*7] ##1 mem_we_n; endsequence
  wr_sel_a: assert property (
    !mem_we_n |-> !select_low_active_n && select_high_active) else $error("strobe without select");
  addr_hold_a: assert property (
    wr_on |-> $stable(mem_addr)) else $error("address moved in write");
  no_fight_a: assert property (
    !mem_oe_n |-> !mem_dq_oe) else $error("bus contention");
  data_drv_a: assert property (
    !mem_we_n |-> mem_dq_oe) else $error("write data not driven");
  data_hold_a: assert property (
    wr_on |-> $stable(mem_dq_out)) else $error("write data moved");
  wr_len_a: assert property (
    $fell(mem_we_n) |-> wr_pulse) else $error("strobe length wrong");
  pd_wait_a: assert property (
    pd_exit |-> ##2 (!ready && mem_we_n && mem_oe_n) [*8]) else $error("access in recovery");
endmodule // asr_host_assertions
bind asr_host asr_host_assertions chk (.mclk, .rst, .pd_exit, .ready, .select_low_active_n,
  .select_high_active, .mem_we_n, .mem_oe_n, .mem_dq_oe, .mem_addr, .mem_dq_out);
`default_nettype wire

// file: verif/asr_mem_model.sv
// Purpose: static memory model. Assumes: fixed ns delays for access and release. Notes: no pull on the bus
`timescale 1ns/1ps
`default_nettype none
module asr_mem_model (
  // pins
  input wire logic [17:0] a,
  input wire logic sel_lo_n, sel_hi, we_n, oe_n,
  input wire logic [7:0] d,
  output logic [7:0] q,
  output logic drv
);
  logic [7:0] m [0:262143];
  logic [7:0] last = 8'h00;
  logic [17:0] a_old;
  logic sel_old, oe_old, rd_old;
  wire logic sel = !sel_lo_n && sel_hi;
  wire logic wr = sel && !we_n;
  wire logic rd = sel && we_n && !oe_n;
  // inertial copies settle after the access times, 5 ns early against edge races
  assign #65 a_old = a;
  assign #65 sel_old = sel;
  assign #30 oe_old = rd;
  // drive lingers after output enable, strobe or select ends the read
  assign #25 rd_old = rd;
  assign drv = rd || rd_old;
  always @(negedge wr) m[a] = d;
  always @* if (rd) last = m[a];
  // released bus shows inverse, never a stale value
  // data shows only once settled; any change shows the inverse at once
  assign q = (rd && oe_old && sel_old && a_old == a) ? m[a] : ~last;
endmodule // asr_mem_model
`default_nettype wire

// file: verif/test_async_sram_256k_x8_interface.sv
// Purpose: host bench. Assumes: 100 MHz. Notes: recovery shortened to 10
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
  $display("ERROR %0t got %h exp %h", $time, g, e); end end
module test_async_sram_256k_x8_interface;
  logic mclk = 0, rst = 1, req = 0, req_write = 0, pd_exit = 0;
  logic [17:0] req_addr = 0, a, prev = 0;
  logic [7:0] req_wdata = 0;
  logic [7:0] ref_mem [logic [17:0]];
  logic ready, rd_valid;
  wire logic select_low_active_n, select_high_active, mem_we_n, mem_oe_n, mem_dq_oe, mem_drv;
  wire logic [7:0] rd_data, mem_dq_out, mq, mem_dq_in;
  wire logic [17:0] mem_addr;
  int err_total = 0, cmp_count = 0, seed = 4476, cyc = 0;
  assign mem_dq_in = mem_dq_oe ? mem_dq_out : mq;
  initial forever #5 mclk = ~mclk;
  asr_host #(.REC_PD_CYC(10)) dut (.mclk, .rst, .req, .req_write, .req_addr, .req_wdata, .pd_exit,
    .ready, .rd_valid, .rd_data, .mem_addr, .select_low_active_n, .select_high_active, .mem_we_n,
    .mem_oe_n, .mem_dq_in, .mem_dq_out, .mem_dq_oe);
  asr_mem_model mem (.a(mem_addr), .sel_lo_n(select_low_active_n), .sel_hi(select_high_active),
    .we_n(mem_we_n), .oe_n(mem_oe_n), .d(mem_dq_in), .q(mq), .drv(mem_drv));
  always @(negedge mclk) if (!rst) `CHK(mem_dq_oe && mem_drv, 1'b0)
  task automatic wait_hi(ref logic s);
    for (int n = 0; n < 40 && s !== 1'b1; n++) begin @(posedge mclk); #1; end
  endtask
  task automatic acc(input logic w, input logic [17:0] ad, input logic [7:0] dd);
    wait_hi(ready);
    req = 1; req_write = w; req_addr = ad; req_wdata = dd;
    @(posedge mclk); #1;
    req = 0;
    if (w) ref_mem[ad] = dd;
    else begin
      wait_hi(rd_valid);
      `CHK(rd_data, ref_mem[ad])
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge mclk) if (++cyc > 20000) begin err_total++; print_verdict(); end
  initial begin
    repeat (2) @(posedge mclk);
    #1 rst = 0;
    // corners first: lowest and highest address, then random
    for (int i = 0; i < 40; i++) begin
      a = i < 2 ? {18{i[0]}} : 18'($random(seed));
      acc(1, a, 8'($random(seed)));
      acc(0, a, 8'h00);
      acc(0, prev, 8'h00);
      prev = a;
    end
    $display("test rw done");
    wait_hi(ready);
    pd_exit = 1;
    @(posedge mclk); #1;
    pd_exit = 0;
    `CHK(ready, 1'b0)
    acc(0, prev, 8'h00);
    $display("test pd done");
    print_verdict();
  end
endmodule // test_async_sram_256k_x8_interface
`default_nettype wire
